// File: inc/sgm_map.vh
// register map, field positions and reset values of the signal modulator
//Contract
//R1: enable bit set mixes; clear forces carriers to ground, modulator to software bit
//R2: disabling keeps source selections; re-enabling reapplies them
//R3: output enable clear keeps mixing but holds modulated output low
//R4: 4-bit field picks modulator among eleven candidates
//R5: codes: 0 soft, 1 pin, 2-5 ccp, 6-7 comp, 8-9 spi, A uart, rest none
//R6: high and low carriers each picked by own 4-bit field
//R7: output is modulator AND high carrier when high, AND low carrier when low
//R8: with sync, carrier switch waits until current carrier pulse falls low
//R9: separate sync bits for high and low carriers
//R10: each carrier inverted by its own polarity bit before mixing
//R11: carrier pin disable bits stop chosen peripheral driving its pin
//R12: software bit is modulator value only when select chooses it
//R13: modulator pin disable stops chosen source peripheral driving its pin
//R14: output invert bit inverts the modulated output
//R15: slew limit bit resets to one; clear disables pad slew limiting
//R16: operation unchanged in sleep if sources stay active
//R17: reset disables module and restores control register defaults
//R18: read-only status bit shows current modulator output value
//R19: control bits 2-1 read zero and ignore writes
//R20: polarity inversion applied before output-enable gating
`ifndef SGM_MAP_VH
`define SGM_MAP_VH
`define SGM_OFS_CTRL      12'h000
`define SGM_OFS_MSRC      12'h004
`define SGM_OFS_HIGH_CARRIER      12'h008
`define SGM_OFS_LOW_CARRIER      12'h00C
`define SGM_BIT_EN        7
`define SGM_BIT_OE        6
`define SGM_BIT_SLR       5
`define SGM_BIT_OPOL      4
`define SGM_BIT_STAT      3
`define SGM_BIT_SWBIT     0
`define SGM_BIT_ODIS      7
`define SGM_BIT_CPOL      6
`define SGM_BIT_CSYNC     5
`define SGM_CTRL_RST      8'h20
`define SGM_CTRL_WMASK    8'hF1
`define SGM_MSRC_WMASK    8'h8F
`define SGM_CAR_WMASK     8'hEF
`define SGM_SRC_RST       8'h00
`define SGM_MS_SOFT       4'h0
`define SGM_MS_PIN        4'h1
`define SGM_MS_CAPTURE_COMPARE_UNIT_ONE       4'h2
`define SGM_MS_CCP2       4'h3
`define SGM_MS_CCP3       4'h4
`define SGM_MS_CCP4       4'h5
`define SGM_MS_CMP1       4'h6
`define SGM_MS_CMP2       4'h7
`define SGM_MS_SPI1       4'h8
`define SGM_MS_SPI2       4'h9
`define SGM_MS_UART       4'hA
`define SGM_CS_GND        4'h0
`define SGM_CS_PIN1       4'h1
`define SGM_CS_PIN2       4'h2
`define SGM_CS_REFCLK     4'h3
`define SGM_CS_CAPTURE_COMPARE_UNIT_ONE       4'h4
`define SGM_CS_CCP2       4'h5
`define SGM_CS_CCP3       4'h6
`define SGM_CS_CCP4       4'h7
`endif

// File: hw/sgm_sync3.v
// three-stage input synchroniser, change accepted when stages two and three agree
`timescale 1ns/1ps
module sgm_sync3 #(
   parameter WIDTH = 1
) (
   input  wire             pclk,
   input  wire             presetn,
   input  wire [WIDTH-1:0] din,
   output wire [WIDTH-1:0] dout
);
   reg [WIDTH-1:0] s1_ff;
   reg [WIDTH-1:0] s2_ff;
   reg [WIDTH-1:0] s3_ff;
   reg [WIDTH-1:0] q_ff;
   reg [WIDTH-1:0] nxt_q;
   integer i;

   // agreement filter reads stages two and three only
   always @* begin
      nxt_q = q_ff;
      for (i = 0; i < WIDTH; i = i + 1) begin
         if (s2_ff[i] == s3_ff[i]) begin
            nxt_q[i] = s2_ff[i];
         end
      end
   end

   // shift chain
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_ff <= {WIDTH{1'b0}};
         s2_ff <= {WIDTH{1'b0}};
         s3_ff <= {WIDTH{1'b0}};
         q_ff  <= {WIDTH{1'b0}};
      end else begin
         s1_ff <= din;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         q_ff  <= nxt_q;
      end
   end

   assign dout = q_ff;
endmodule // sgm_sync3

// File: hw/sgm_carrier.v
// carrier path: source select, polarity, synchronised switch gating
`timescale 1ns/1ps
`include "sgm_map.vh"
module sgm_carrier (
   input  wire       pclk,
   input  wire       presetn,
   input  wire [3:0] sel,
   input  wire       invert,
   input  wire       sync_en,
   input  wire       active,
   input  wire       pin1,
   input  wire       pin2,
   input  wire       refclk,
   input  wire [3:0] ccp,
   output wire       carrier
);
   reg raw;
   reg live_ff;
   reg nxt_live;

   // source mux, unlisted codes fall to ground
   always @* begin
      case (sel)
         `SGM_CS_PIN1:   raw = pin1;
         `SGM_CS_PIN2:   raw = pin2;
         `SGM_CS_REFCLK: raw = refclk;
         `SGM_CS_CAPTURE_COMPARE_UNIT_ONE:   raw = ccp[0];
         `SGM_CS_CCP2:   raw = ccp[1];
         `SGM_CS_CCP3:   raw = ccp[2];
         `SGM_CS_CCP4:   raw = ccp[3];
         default:        raw = 1'b0;
      endcase
   end

   wire pol = raw ^ invert; // [R10]

   // with sync, a newly selected carrier joins only at a low level, and a
   // deselected one keeps running until its pulse falls: no truncated pulse
   always @* begin
      nxt_live = live_ff;
      if (!sync_en) begin
         nxt_live = active;
      end else if (active && !pol) begin
         nxt_live = 1'b1;
      end else if (!active && !pol) begin
         nxt_live = 1'b0;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         live_ff <= 1'b0;
      end else begin
         live_ff <= nxt_live;
      end
   end

   // unsynced path is combinational so carriers switch at once
   assign carrier = (sync_en ? live_ff : active) & pol; // [R8] [R9]
endmodule // sgm_carrier

// File: hw/sgm_modulator.v
// signal modulator: apb registers, source selection, mixing and output
`timescale 1ns/1ps
`include "sgm_map.vh"
module sgm_modulator (
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   input  wire [3:0]  pstrb,
   output wire        pready,
   output reg  [31:0] prdata,
   output wire        pslverr,
   input  wire        external_modulator_pin,
   input  wire        external_carrier_pin_one,
   input  wire        external_carrier_pin_two,
   input  wire [3:0]  ccp_out,
   input  wire [1:0]  spi_data_out,
   input  wire [1:0]  comparator_out,
   input  wire        uart_tx,
   input  wire        reference_clock,
   output reg         modulated_output,
   output wire        slew_limit_bit,
   output reg  [3:0]  ccp_pin_disable,
   output reg  [1:0]  spi_pin_disable,
   output reg  [1:0]  comparator_pin_disable,
   output reg         uart_pin_disable
);
   reg  [7:0] ctrl_ff;
   reg  [7:0] msrc_ff;
   reg  [7:0] high_carrier_ff;
   reg  [7:0] low_carrier_ff;
   reg        stat_ff;
   reg        mod_ff;
   reg        mod_sel;
   wire       mixed;
   wire       car_h;
   wire       car_l;
   wire [2:0] pins_s;

   // pins cross in through four flops; peripherals share the clock
   sgm_sync3 #(.WIDTH(3)) u_pins (
      .pclk    (pclk),
      .presetn (presetn),
      .din     ({external_carrier_pin_two, external_carrier_pin_one,
                 external_modulator_pin}),
      .dout    (pins_s)
   );

   // apb: zero wait, all offsets answer okay, unmapped read zero
   wire acc    = psel & penable;
   wire wr     = acc & pwrite & pstrb[0];
   wire en     = ctrl_ff[`SGM_BIT_EN];
   assign pready  = 1'b1;
   assign pslverr = 1'b0;

   // writes; bits 2-1 and status never stored [R19]
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_ff <= `SGM_CTRL_RST; // [R17] [R15]
         msrc_ff <= `SGM_SRC_RST;
         high_carrier_ff <= `SGM_SRC_RST;
         low_carrier_ff <= `SGM_SRC_RST;
      end else if (wr) begin
         case (paddr)
            `SGM_OFS_CTRL: ctrl_ff <= pwdata[7:0] & `SGM_CTRL_WMASK;
            `SGM_OFS_MSRC: msrc_ff <= pwdata[7:0] & `SGM_MSRC_WMASK;
            `SGM_OFS_HIGH_CARRIER: high_carrier_ff <= pwdata[7:0] & `SGM_CAR_WMASK;
            `SGM_OFS_LOW_CARRIER: low_carrier_ff <= pwdata[7:0] & `SGM_CAR_WMASK;
            default: ;
         endcase
      end
   end

   // read mux; status bit sampled, may lag fast streams [R18]
   always @* begin
      case (paddr)
         `SGM_OFS_CTRL: prdata = {24'h000000, ctrl_ff[7:4], stat_ff, 3'h0} |
                                 {31'h00000000, ctrl_ff[`SGM_BIT_SWBIT]};
         `SGM_OFS_MSRC: prdata = {24'h000000, msrc_ff};
         `SGM_OFS_HIGH_CARRIER: prdata = {24'h000000, high_carrier_ff};
         `SGM_OFS_LOW_CARRIER: prdata = {24'h000000, low_carrier_ff};
         default:       prdata = 32'h00000000;
      endcase
   end

   // selections stay stored while disabled; only the applied code changes
   wire [3:0] ms_eff = en ? msrc_ff[3:0] : `SGM_MS_SOFT; // [R1] [R2]
   wire [3:0] ch_eff = en ? high_carrier_ff[3:0] : `SGM_CS_GND;  // [R1] [R2]
   wire [3:0] cl_eff = en ? low_carrier_ff[3:0] : `SGM_CS_GND;  // [R1] [R2]

   // modulator source mux [R4] [R5]
   always @* begin
      case (ms_eff)
         `SGM_MS_SOFT: mod_sel = ctrl_ff[`SGM_BIT_SWBIT]; // [R12]
         `SGM_MS_PIN:  mod_sel = pins_s[0];
         `SGM_MS_CAPTURE_COMPARE_UNIT_ONE: mod_sel = ccp_out[0];
         `SGM_MS_CCP2: mod_sel = ccp_out[1];
         `SGM_MS_CCP3: mod_sel = ccp_out[2];
         `SGM_MS_CCP4: mod_sel = ccp_out[3];
         `SGM_MS_CMP1: mod_sel = comparator_out[0];
         `SGM_MS_CMP2: mod_sel = comparator_out[1];
         `SGM_MS_SPI1: mod_sel = spi_data_out[0];
         `SGM_MS_SPI2: mod_sel = spi_data_out[1];
         `SGM_MS_UART: mod_sel = uart_tx;
         default:      mod_sel = 1'b0;
      endcase
   end

   // registered modulator so carrier gating and mix see one edge
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mod_ff <= 1'b0;
      end else begin
         mod_ff <= mod_sel;
      end
   end

   // two carrier paths, each with its own select, polarity and sync [R6] [R9]
   sgm_carrier u_high_carrier (
      .pclk    (pclk),
      .presetn (presetn),
      .sel     (ch_eff),
      .invert  (high_carrier_ff[`SGM_BIT_CPOL]),
      .sync_en (high_carrier_ff[`SGM_BIT_CSYNC]),
      .active  (mod_ff),
      .pin1    (pins_s[1]),
      .pin2    (pins_s[2]),
      .refclk  (reference_clock),
      .ccp     (ccp_out),
      .carrier (car_h)
   );

   sgm_carrier u_low_carrier (
      .pclk    (pclk),
      .presetn (presetn),
      .sel     (cl_eff),
      .invert  (low_carrier_ff[`SGM_BIT_CPOL]),
      .sync_en (low_carrier_ff[`SGM_BIT_CSYNC]),
      .active  (~mod_ff),
      .pin1    (pins_s[1]),
      .pin2    (pins_s[2]),
      .refclk  (reference_clock),
      .ccp     (ccp_out),
      .carrier (car_l)
   );

   // high carrier gated by modulator, low by its inverse; the carrier
   // gating already carries the modulator level, so a sync tail may overlap
   assign mixed = car_h | car_l; // [R7] [R8]

   // polarity first, then enable gating so a disabled pin stays low [R20]
   wire pol_out = mixed ^ ctrl_ff[`SGM_BIT_OPOL]; // [R14]
   wire pin_nxt = en & ctrl_ff[`SGM_BIT_OE] & pol_out; // [R3] [R1]

   // no gated clocks, so logic is sleep-agnostic [R16]
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         modulated_output <= 1'b0;
         stat_ff          <= 1'b0;
      end else begin
         modulated_output <= pin_nxt;
         stat_ff          <= en & pol_out; // [R18]
      end
   end

   assign slew_limit_bit = ctrl_ff[`SGM_BIT_SLR]; // [R15]

   // pin disable goes to whichever peripheral is currently selected
   always @* begin
      ccp_pin_disable        = 4'h0;
      spi_pin_disable        = 2'h0;
      comparator_pin_disable = 2'h0;
      uart_pin_disable       = 1'b0;
      case (msrc_ff[3:0]) // [R13]
         `SGM_MS_CAPTURE_COMPARE_UNIT_ONE: ccp_pin_disable[0]        = msrc_ff[`SGM_BIT_ODIS];
         `SGM_MS_CCP2: ccp_pin_disable[1]        = msrc_ff[`SGM_BIT_ODIS];
         `SGM_MS_CCP3: ccp_pin_disable[2]        = msrc_ff[`SGM_BIT_ODIS];
         `SGM_MS_CCP4: ccp_pin_disable[3]        = msrc_ff[`SGM_BIT_ODIS];
         `SGM_MS_CMP1: comparator_pin_disable[0] = msrc_ff[`SGM_BIT_ODIS];
         `SGM_MS_CMP2: comparator_pin_disable[1] = msrc_ff[`SGM_BIT_ODIS];
         `SGM_MS_SPI1: spi_pin_disable[0]        = msrc_ff[`SGM_BIT_ODIS];
         `SGM_MS_SPI2: spi_pin_disable[1]        = msrc_ff[`SGM_BIT_ODIS];
         `SGM_MS_UART: uart_pin_disable          = msrc_ff[`SGM_BIT_ODIS];
         default: ;
      endcase
      // carrier ccp selections; codes 4..7 map to ccp 1..4 [R11]
      if (high_carrier_ff[3:2] == 2'h1) begin
         ccp_pin_disable[high_carrier_ff[1:0]] = ccp_pin_disable[high_carrier_ff[1:0]] |
                                         high_carrier_ff[`SGM_BIT_ODIS];
      end
      if (low_carrier_ff[3:2] == 2'h1) begin
         ccp_pin_disable[low_carrier_ff[1:0]] = ccp_pin_disable[low_carrier_ff[1:0]] |
                                         low_carrier_ff[`SGM_BIT_ODIS];
      end
   end
endmodule // sgm_modulator

// File: sim/sgm_modulator_assertions.sv
// port assertions for the signal modulator, bound into its top module
`timescale 1ns/1ps
module sgm_checker (
   input wire        pclk,
   input wire        presetn,
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [3:0]  pstrb,
   input wire [31:0] prdata,
   input wire        modulated_output,
   input wire        slew_limit_bit,
   input wire [1:0]  spi_pin_disable,
   input wire [1:0]  comparator_pin_disable,
   input wire        uart_pin_disable
);
   reg [7:0] wd_ff;
   // write byte kept one edge, pin disables are judged after the write lands
   always @(posedge pclk) begin
      wd_ff <= pwdata[7:0];
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence wr_at(logic [11:0] a);
      psel && penable && pwrite && pstrb[0] && paddr == a;
   endsequence
   sequence rd_ctrl;
      psel && !pwrite && paddr == 12'h000;
   endsequence
   a_off_out_low: assert property (
      wr_at(12'h000) ##0 !pwdata[7] |-> ##2 !modulated_output [*2])
      else $error("output high with module disabled");
   a_oe_out_low: assert property (
      wr_at(12'h000) ##0 !pwdata[6] |-> ##2 !modulated_output [*2])
      else $error("output high with pin output off");
   a_gap_bits_zero: assert property (rd_ctrl |-> prdata[2:1] == 2'h0)
      else $error("unused control bits read nonzero");
   a_slew_mirror: assert property (rd_ctrl |-> prdata[5] == slew_limit_bit)
      else $error("slew output differs from its bit");
   a_status_tracks_out: assert property (
      rd_ctrl ##0 prdata[6] |-> prdata[3] == modulated_output)
      else $error("status bit differs from output");
   a_uart_pin_off: assert property (
      wr_at(12'h004) |=> uart_pin_disable == (wd_ff[7] && wd_ff[3:0] == 4'hA))
      else $error("uart pin disable wrong");
   a_spi_pin_off: assert property (wr_at(12'h004) |=> spi_pin_disable ==
      {wd_ff[7] && wd_ff[3:0] == 4'h9, wd_ff[7] && wd_ff[3:0] == 4'h8})
      else $error("spi pin disable wrong");
   a_cmp_pin_off: assert property (wr_at(12'h004) |=> comparator_pin_disable ==
      {wd_ff[7] && wd_ff[3:0] == 4'h7, wd_ff[7] && wd_ff[3:0] == 4'h6})
      else $error("comparator pin disable wrong");
   a_reset_defaults: assert property (
      $rose(presetn) |-> slew_limit_bit && !modulated_output)
      else $error("reset values wrong");
endmodule // sgm_checker
bind sgm_modulator sgm_checker u_sgm_checker (.pclk, .presetn, .psel, .penable, .pwrite,
   .paddr, .pwdata, .pstrb, .prdata, .modulated_output, .slew_limit_bit, .spi_pin_disable,
   .comparator_pin_disable, .uart_pin_disable);

// File: sim/sgm_partner.sv
// far-side peripherals and pins feeding the signal modulator
`timescale 1ns/1ps
module sgm_partner (
   input  wire        pclk,
   input  wire [13:0] lvl,
   output wire        external_modulator_pin,
   output wire        external_carrier_pin_one,
   output wire        external_carrier_pin_two,
   output wire [3:0]  ccp_out,
   output wire [1:0]  spi_data_out,
   output wire [1:0]  comparator_out,
   output wire        uart_tx,
   output wire        reference_clock
);
   reg [13:0] drive_ff;
   // peripherals launch from a clock edge, so levels never move mid-cycle
   always @(posedge pclk) begin
      drive_ff <= lvl;
   end
   // bit 0 is unused: the software bit lives in the control register
   assign {reference_clock, external_carrier_pin_two, external_carrier_pin_one, uart_tx,
      spi_data_out, comparator_out, ccp_out, external_modulator_pin} = drive_ff[13:1];
endmodule // sgm_partner

// File: sim/sgm_modulator_bench.sv
// self-checking bench of the signal modulator
`timescale 1ns/1ps
module sgm_modulator_bench;
   reg         pclk = 1'b0;
   reg         presetn = 1'b0;
   reg         psel = 1'b0;
   reg         penable = 1'b0;
   reg         pwrite = 1'b0;
   reg  [11:0] paddr = 12'h000;
   reg  [31:0] pwdata = 32'h00000000;
   reg  [3:0]  pstrb = 4'hF;
   reg  [13:0] lvl = 14'h0000;
   reg  [31:0] rq;
   wire [31:0] prdata;
   wire        pready, pslverr, modulated_output, slew_limit_bit, uart_pin_disable;
   wire        external_modulator_pin, external_carrier_pin_one, external_carrier_pin_two;
   wire        uart_tx, reference_clock;
   wire [3:0]  ccp_out, ccp_pin_disable;
   wire [1:0]  spi_data_out, comparator_out, spi_pin_disable, comparator_pin_disable;
   integer     fail_count = 0;
   integer     comparisons = 0;
   sgm_modulator u_sgm_modulator (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .pstrb, .pready, .prdata, .pslverr, .external_modulator_pin, .external_carrier_pin_one,
      .external_carrier_pin_two, .ccp_out, .spi_data_out, .comparator_out, .uart_tx,
      .reference_clock, .modulated_output, .slew_limit_bit, .ccp_pin_disable,
      .spi_pin_disable, .comparator_pin_disable, .uart_pin_disable);
   sgm_partner u_sgm_partner (.pclk, .lvl, .external_modulator_pin, .external_carrier_pin_one,
      .external_carrier_pin_two, .ccp_out, .spi_data_out, .comparator_out, .uart_tx,
      .reference_clock);
   // 200 MHz clock
   always #2.5 pclk = ~pclk;
   task chk(input [31:0] got, input [31:0] exp);
      begin
         comparisons = comparisons + 1;
         if (got !== exp) begin
            fail_count = fail_count + 1;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   // request held until pready, then an idle cycle so writes never abut
   task apb(input w, input [11:0] a, input [7:0] d);
      begin
         psel <= 1'b1;
         pwrite <= w;
         paddr <= a;
         pwdata <= {24'h000000, d};
         @(posedge pclk);
         penable <= 1'b1;
         @(posedge pclk);
         // no local limit: only the watchdog ends a wait
         while (pready !== 1'b1) begin
            @(posedge pclk);
         end
         rq = prdata;
         chk(pslverr, 0); // bus never flags an error
         psel <= 1'b0;
         penable <= 1'b0;
         @(posedge pclk);
      end
   endtask
   task wr(input [11:0] a, input [7:0] d);
      apb(1'b1, a, d);
   endtask
   task rd(input [11:0] a, input [7:0] e);
      begin
         apb(1'b0, a, 8'h00);
         chk(rq, e);
      end
   endtask
   // long enough for the pin synchroniser and the output pipeline
   task w8;
      repeat (8) @(posedge pclk);
   endtask
   task t_reset;
      begin
         rd(12'h000, 8'h20);
         rd(12'h004, 8'h00);
         rd(12'h008, 8'h00);
         rd(12'h00C, 8'h00);
         rd(12'h010, 8'h00);
         $display("reset test done");
      end
   endtask
   task t_ctrl;
      begin
         wr(12'h000, 8'hFF);
         rd(12'h000, 8'hF9);
         chk(modulated_output, 1);
         wr(12'h000, 8'hB1);
         rd(12'h000, 8'hB9);
         chk(modulated_output, 0);
         wr(12'h000, 8'h00);
         chk(slew_limit_bit, 0);
         $display("control test done");
      end
   endtask
   // selected source follows, every other source shows the opposite level
   task t_mod;
      integer c, v;
      reg [13:0] m;
      begin
         wr(12'h008, 8'h40);
         for (c = 0; c < 12; c = c + 1) begin
            for (v = 0; v < 2; v = v + 1) begin
               m = v ? (14'h1 << c) : ~(14'h1 << c);
               lvl <= m;
               wr(12'h004, c[7:0]);
               wr(12'h000, {7'h60, m[0]});
               w8;
               chk(modulated_output, v && c < 11);
            end
         end
         $display("modulator test done");
      end
   endtask
   task t_car;
      integer k;
      reg [13:0] m;
      begin
         wr(12'h004, 8'h00);
         wr(12'h000, 8'hC1);
         for (k = 0; k < 16; k = k + 1) begin
            m = (k[2:0] == 0) ? 14'h3FFF : (k[2:0] < 4) ? 14'h400 << k[2:0] : 14'h1 << (k[2:0] - 2);
            lvl <= m;
            wr(12'h008, {1'b0, k[3], 3'b000, k[2:0]});
            w8;
            chk(modulated_output, (k[2:0] != 0) ^ k[3]);
         end
         wr(12'h00C, 8'h40);
         wr(12'h000, 8'hC0);
         w8;
         // modulator low: the inverted grounded low carrier reaches the pin
         chk(modulated_output, 1);
         $display("carrier test done");
      end
   endtask
   task t_sync(input s);
      begin
         wr(12'h004, 8'h00);
         wr(12'h008, {2'b00, s, 5'h04});
         wr(12'h00C, {2'b00, !s, 5'h00});
         lvl <= 14'h0000;
         wr(12'h000, 8'hC1);
         w8;
         lvl <= 14'h0004;
         w8;
         chk(modulated_output, 1);
         wr(12'h000, 8'hC0);
         w8;
         chk(modulated_output, s);
         lvl <= 14'h0000;
         w8;
         chk(modulated_output, 0);
         $display("sync test done");
      end
   endtask
   task t_dis;
      begin
         wr(12'h004, 8'h02);
         wr(12'h008, 8'h40);
         lvl <= 14'h0004;
         wr(12'h000, 8'h40);
         w8;
         chk(modulated_output, 0);
         rd(12'h004, 8'h02);
         wr(12'h000, 8'hC0);
         w8;
         chk(modulated_output, 1);
         $display("disable test done");
      end
   endtask
   task t_pin;
      begin
         wr(12'h008, 8'h84);
         wr(12'h00C, 8'h87);
         chk(ccp_pin_disable, 4'h9);
         wr(12'h004, 8'h8A);
         chk(uart_pin_disable, 1);
         wr(12'h004, 8'h89);
         chk(spi_pin_disable, 2'h2);
         wr(12'h004, 8'h87);
         chk(comparator_pin_disable, 2'h2);
         $display("pin disable test done");
      end
   endtask
   // reset in mid-run must drop every written setting
   task t_rerun;
      begin
         presetn <= 1'b0;
         repeat (2) @(posedge pclk);
         presetn <= 1'b1;
         @(posedge pclk);
         chk(ccp_pin_disable, 4'h0);
         chk(modulated_output, 0);
         t_reset;
      end
   endtask
   task conclude;
      begin
         $display("comparisons %0d mismatches %0d", comparisons, fail_count);
         if (fail_count == 0 && comparisons > 0)
            $display("DONE - PASS");
         else
            $display("DONE - FAIL");
         $finish;
      end
   endtask
   // main sequence
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_reset;
      t_ctrl;
      t_mod;
      t_car;
      t_sync(1'b1);
      t_sync(1'b0);
      t_dis;
      t_pin;
      t_rerun;
      conclude;
   end
   // watchdog, far beyond the fewer than one thousand cycles the tests take
   initial begin
      #100000;
      fail_count = fail_count + 1;
      conclude;
   end
endmodule // sgm_modulator_bench
